// File: verilog/fps_sequencer.sv
// Fuel pump sequencer top: panel decoding, five-pump rotation, set points and AHB-Lite register slave.
// Assumes panel pins are asynchronous; the pump fail and flow inputs come from other clocked logic.
`default_nettype none
`include "fps_params.svh"
module fps_sequencer (
  input  wire logic               core_clk,
  input  wire logic               rst_n,
  input  wire logic               clkEn,
  input  wire fps_pkg::fps_panel_t panelPins,
  input  wire logic               cpuAFault,
  input  wire logic               cpuBFault,
  input  wire logic               powerRestoredCold,
  input  wire logic [9:0]         pumpFail,
  input  wire logic [15:0]        issueFlow,
  input  wire logic [15:0]        sysPressure,
  input  wire logic               hsel,
  input  wire logic [31:0]        haddr,
  input  wire logic [1:0]         htrans,
  input  wire logic               hwrite,
  input  wire logic [2:0]         hsize,
  input  wire logic [31:0]        hwdata,
  input  wire logic               hready,
  output logic      [31:0]        hrdata,
  output logic                    hreadyout,
  output logic                    hresp,
  output logic      [9:0]         pumpRun,
  output fps_pkg::fps_annun_t     annun,
  output fps_pkg::fps_mode_t      activeMode,
  output logic                    activeSystemB,
  output logic                    operTankB,
  output logic      [3:0]         leadPumpNum
);
  import fps_pkg::*;

  // ******************************
  // Input synchronisers
  // ******************************
  fps_panel_t panelMeta_q, panel_q;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      panelMeta_q <= '0;
      panel_q     <= '0;
    end else if (clkEn) begin
      panelMeta_q <= panelPins;
      panel_q     <= panelMeta_q;
    end
  end

  // ******************************
  // Panel decoding and annunciation
  // ******************************
  function automatic fps_mode_t decodeMode(input logic [3:0] sel);
    case (sel)
      4'b0001: decodeMode = MODE_AUTO;
      4'b0010: decodeMode = MODE_FLUSH;
      4'b0100: decodeMode = MODE_TEST;
      default: decodeMode = MODE_OFF;
    endcase
  endfunction

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      annun          <= '0;
      activeMode     <= MODE_OFF;
      activeSystemB  <= 1'b0;
      operTankB      <= 1'b0;
    end else if (clkEn) begin
      annun.cpuAOnLamp   <= !cpuAFault;
      annun.cpuBOnLamp   <= !cpuBFault;
      annun.nonCritAlarm <= cpuAFault || cpuBFault || panel_q.overTemp;
      annun.critAlarm    <= panel_q.estop;
      activeMode         <= decodeMode(panel_q.modeSel);
      activeSystemB      <= panel_q.inputSel;
      operTankB          <= panel_q.tankSel;
    end
  end

  // ******************************
  // Set points: defaults and working copies
  // ******************************
  logic [15:0] defPress_q, defFlow2_q, defFlow3_q, defEstab_q;
  logic [15:0] wrkPress_q, wrkFlow2_q, wrkFlow3_q, wrkEstab_q;
  logic        unlocked_q;
  logic [31:0] ctrl_q;
  logic [1:0]  defSel_q;
  logic        reload;
  logic        doWrite;
  logic [7:0]  wrAddr_q;
  logic        wrPend_q;
  parameter logic [31:0] UNLOCK_KEY = 32'h5A5A_C3C3; // Arbitrary unlock word.

  function automatic logic [15:0] clampVal(input logic [31:0] v, input logic [15:0] lo, input logic [15:0] hi);
    if (v < 32'(lo)) clampVal = lo;
    else if (v > 32'(hi)) clampVal = hi;
    else clampVal = v[15:0];
  endfunction

  assign doWrite = wrPend_q;
  assign reload  = powerRestoredCold || (doWrite && wrAddr_q == `FPS_OFF_CTRL && hwdata[1]);

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      defPress_q <= `FPS_PRESS_DEF;
      defFlow2_q <= `FPS_FLOW2_DEF;
      defFlow3_q <= `FPS_FLOW3_DEF;
      defEstab_q <= `FPS_ESTAB_DEF;
      unlocked_q <= 1'b0;
      defSel_q   <= 2'd0;
    end else if (clkEn && doWrite) begin
      if (wrAddr_q == `FPS_OFF_PASSWORD) begin
        unlocked_q <= (hwdata == UNLOCK_KEY);
      end
      if (wrAddr_q == `FPS_OFF_DEFSEL) begin
        defSel_q <= hwdata[1:0];
      end
      if (wrAddr_q == `FPS_OFF_DEFDATA && unlocked_q) begin
        case (defSel_q)
          2'd0:    defPress_q <= clampVal(hwdata, `FPS_PRESS_MIN, `FPS_PRESS_MAX);
          2'd1:    defFlow2_q <= clampVal(hwdata, `FPS_FLOW2_MIN, `FPS_FLOW2_MAX);
          2'd2:    defFlow3_q <= clampVal(hwdata, `FPS_FLOW3_MIN, `FPS_FLOW3_MAX);
          default: defEstab_q <= clampVal(hwdata, `FPS_ESTAB_MIN, `FPS_ESTAB_MAX);
        endcase
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wrkPress_q <= `FPS_PRESS_DEF;
      wrkFlow2_q <= `FPS_FLOW2_DEF;
      wrkFlow3_q <= `FPS_FLOW3_DEF;
      wrkEstab_q <= `FPS_ESTAB_DEF;
    end else if (clkEn) begin
      if (reload) begin
        wrkPress_q <= defPress_q;
        wrkFlow2_q <= defFlow2_q;
        wrkFlow3_q <= defFlow3_q;
        wrkEstab_q <= defEstab_q;
      end else if (doWrite) begin
        case (wrAddr_q)
          `FPS_OFF_PRESS: wrkPress_q <= clampVal(hwdata, `FPS_PRESS_MIN, `FPS_PRESS_MAX);
          `FPS_OFF_FLOW2: wrkFlow2_q <= clampVal(hwdata, `FPS_FLOW2_MIN, `FPS_FLOW2_MAX);
          `FPS_OFF_FLOW3: wrkFlow3_q <= clampVal(hwdata, `FPS_FLOW3_MIN, `FPS_FLOW3_MAX);
          `FPS_OFF_ESTAB: wrkEstab_q <= clampVal(hwdata, `FPS_ESTAB_MIN, `FPS_ESTAB_MAX);
          default: ;
        endcase
      end
    end
  end

  // ******************************
  // Start order
  // ******************************
  logic [14:0] order;
  fps_order_rom uOrder (
    .leadOneHot (operTankB ? panel_q.leadSelB : panel_q.leadSelA),
    .order      (order)
  );
  logic [3:0] tankBase;
  assign tankBase = operTankB ? 4'd6 : 4'd1;
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      leadPumpNum <= 4'd1;
    end else if (clkEn) begin
      leadPumpNum <= tankBase + 4'(order[2:0]);
    end
  end

  // ******************************
  // Sequencer
  // ******************************
  // A one-millisecond tick keeps the seconds counter narrow.
  localparam int TickCycles = `FPS_TICK_CYCLES;
  logic [16:0] tickCnt_q;
  logic        tick;
  assign tick = (tickCnt_q == 17'(TickCycles - 1));
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      tickCnt_q <= '0;
    end else if (clkEn) begin
      tickCnt_q <= tick ? '0 : tickCnt_q + 17'd1;
    end
  end

  logic [4:0]  running_q;
  logic [4:0]  disabled_q;
  logic [2:0]  started_q;
  logic [24:0] timer_q;
  logic        enableRun;
  logic [4:0]  localFail;
  logic [2:0]  nextIdx;
  logic [2:0]  lastIdx;
  logic [15:0] stageFlow;
  logic        stepUp;
  logic        timerDone;
  logic [2:0]  runCount;

  assign localFail = operTankB ? pumpFail[9:5] : pumpFail[4:0];
  assign enableRun = (activeMode == MODE_AUTO) && !panel_q.estop;
  assign timerDone = (timer_q == 25'd0);
  assign stageFlow = (started_q == 3'd1) ? wrkFlow2_q : wrkFlow3_q;
  always_comb begin
    runCount = 3'd0;
    for (int i = 0; i < 5; i++) begin
      runCount = runCount + 3'(running_q[i]);
    end
  end

  // Skip disabled pumps, so a failed pump hands its slot to the next one in order.
  always_comb begin
    nextIdx = 3'd7;
    for (int k = 4; k >= 0; k--) begin
      if (!disabled_q[order[k*3 +: 3]] && !running_q[order[k*3 +: 3]]) begin
        nextIdx = order[k*3 +: 3];
      end
    end
    lastIdx = 3'd7;
    for (int k = 0; k < 5; k++) begin
      if (running_q[order[k*3 +: 3]]) begin
        lastIdx = order[k*3 +: 3];
      end
    end
  end

  always_comb begin
    if (started_q == 3'd0) stepUp = sysPressure < wrkPress_q;
    else stepUp = (issueFlow > stageFlow) && (started_q < `FPS_MAX_RUN);
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      running_q  <= '0;
      disabled_q <= '0;
      started_q  <= '0;
      timer_q    <= '0;
    end else if (clkEn) begin
      disabled_q <= disabled_q | (localFail & running_q);
      if (!timerDone && tick) begin
        timer_q <= timer_q - 25'd1;
      end
      if (!enableRun) begin
        running_q <= '0;
        started_q <= '0;
      end else if (|(localFail & running_q)) begin
        running_q <= running_q & ~localFail;
        started_q <= started_q - 3'd1;
        timer_q   <= '0;
      end else if (stepUp && timerDone && nextIdx != 3'd7 && runCount < `FPS_MAX_RUN) begin
        running_q[nextIdx] <= 1'b1;
        started_q          <= started_q + 3'd1;
        timer_q            <= 25'(wrkEstab_q) * 25'(`FPS_TICKS_PER_S);
      end else if (!stepUp && started_q != 3'd0 && timerDone && lastIdx != 3'd7) begin
        running_q[lastIdx] <= 1'b0;
        started_q          <= started_q - 3'd1;
      end
    end
  end

  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pumpRun <= '0;
    end else if (clkEn) begin
      pumpRun <= operTankB ? {running_q, 5'b0} : {5'b0, running_q};
    end
  end

  // ******************************
  // AHB-Lite slave
  // ******************************
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      wrPend_q  <= 1'b0;
      wrAddr_q  <= '0;
      hrdata    <= '0;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
      ctrl_q    <= '0;
    end else if (clkEn) begin
      wrPend_q <= hsel && hready && htrans[1] && hwrite;
      if (hsel && hready && htrans[1]) begin
        wrAddr_q <= haddr[7:0];
        if (!hwrite) begin
          case (haddr[7:0])
            `FPS_OFF_CTRL:   hrdata <= ctrl_q;
            `FPS_OFF_STATUS: hrdata <= {20'd0, leadPumpNum, operTankB, activeSystemB, 2'd0, activeMode};
            `FPS_OFF_PRESS:  hrdata <= {16'd0, wrkPress_q};
            `FPS_OFF_FLOW2:  hrdata <= {16'd0, wrkFlow2_q};
            `FPS_OFF_FLOW3:  hrdata <= {16'd0, wrkFlow3_q};
            `FPS_OFF_ESTAB:  hrdata <= {16'd0, wrkEstab_q};
            `FPS_OFF_DEFSEL: hrdata <= {29'd0, unlocked_q, defSel_q};
            `FPS_OFF_PUMPS:  hrdata <= {22'd0, disabled_q, running_q};
            default:         hrdata <= '0;
          endcase
        end
      end
      if (wrPend_q && wrAddr_q == `FPS_OFF_CTRL) begin
        ctrl_q <= {30'd0, 1'b0, hwdata[0]};
      end
    end
  end

  // ******************************
  // Checks
  // ******************************
  a_run_limit: assert property (@(posedge core_clk) disable iff (!rst_n) runCount <= 3'd4)
    else $error("more than four pumps running");
  a_estop_cancel: assert property (@(posedge core_clk) disable iff (!rst_n)
    clkEn && panel_q.estop |=> running_q == '0)
    else $error("pump left running under emergency stop");
  a_crit_alarm: assert property (@(posedge core_clk) disable iff (!rst_n)
    clkEn && panel_q.estop |=> annun.critAlarm)
    else $error("critical alarm missing");
  a_lamp_fault: assert property (@(posedge core_clk) disable iff (!rst_n)
    clkEn && cpuAFault |=> !annun.cpuAOnLamp && annun.nonCritAlarm)
    else $error("faulted processor lamp still lit");
  a_lamp_ok: assert property (@(posedge core_clk) disable iff (!rst_n)
    clkEn && !cpuBFault |=> annun.cpuBOnLamp)
    else $error("healthy processor lamp dark");
  a_overtemp_alarm: assert property (@(posedge core_clk) disable iff (!rst_n)
    clkEn && panel_q.overTemp |=> annun.nonCritAlarm)
    else $error("over-temperature alarm missing");
  a_press_range: assert property (@(posedge core_clk) disable iff (!rst_n)
    wrkPress_q >= 16'd205 && wrkPress_q <= 16'd1035)
    else $error("pressure set point out of range");
  a_estab_range: assert property (@(posedge core_clk) disable iff (!rst_n)
    wrkEstab_q >= 16'd5 && wrkEstab_q <= 16'd30 && wrkFlow2_q <= 16'd40 && wrkFlow3_q >= 16'd65)
    else $error("set point out of range");
  a_locked_default: assert property (@(posedge core_clk) disable iff (!rst_n)
    !unlocked_q |=> $stable(defPress_q))
    else $error("default changed without password");
  a_cold_reload: assert property (@(posedge core_clk) disable iff (!rst_n)
    clkEn && powerRestoredCold |=> wrkEstab_q == $past(defEstab_q))
    else $error("set point not restored");
  a_disable_fail: assert property (@(posedge core_clk) disable iff (!rst_n)
    clkEn && |(localFail & running_q) |=> |(disabled_q & $past(localFail)))
    else $error("failed pump not disabled");
  c_start_pump: cover property (@(posedge core_clk) disable iff (!rst_n) $rose(|running_q));
  c_four_run: cover property (@(posedge core_clk) disable iff (!rst_n) runCount == 3'd4);
  c_fail_skip: cover property (@(posedge core_clk) disable iff (!rst_n) |disabled_q && |running_q);
  c_estop_stop: cover property (@(posedge core_clk) disable iff (!rst_n) $fell(|running_q) && panel_q.estop);
endmodule
`default_nettype wire

// File: verilog/fps_params.svh
// Constants of the fuel pump sequencer: register offsets, reset values, set point limits and timing counts.
// Assumes a 100 MHz core clock and a 32-bit AHB-Lite register port.
`ifndef FPS_PARAMS_SVH
`define FPS_PARAMS_SVH

`define FPS_OFF_CTRL      8'h00
`define FPS_OFF_STATUS    8'h04
`define FPS_OFF_PRESS     8'h08
`define FPS_OFF_FLOW2     8'h0C
`define FPS_OFF_FLOW3     8'h10
`define FPS_OFF_ESTAB     8'h14
`define FPS_OFF_PASSWORD  8'h18
`define FPS_OFF_DEFSEL    8'h1C
`define FPS_OFF_DEFDATA   8'h20
`define FPS_OFF_PUMPS     8'h24

`define FPS_PRESS_MIN     16'd205
`define FPS_PRESS_MAX     16'd1035
`define FPS_PRESS_DEF     16'd415
`define FPS_FLOW2_MIN     16'd25
`define FPS_FLOW2_MAX     16'd40
`define FPS_FLOW2_DEF     16'd35
`define FPS_FLOW3_MIN     16'd65
`define FPS_FLOW3_MAX     16'd80
`define FPS_FLOW3_DEF     16'd73
`define FPS_ESTAB_MIN     16'd5
`define FPS_ESTAB_MAX     16'd30
`define FPS_ESTAB_DEF     16'd15

`define FPS_MAX_RUN       3'd4
`define FPS_CLK_HZ        100000000
`define FPS_TICK_NS       1000000
`define FPS_TICK_CYCLES   ((`FPS_TICK_NS * (`FPS_CLK_HZ / 1000000)) / 1000)
`define FPS_TICKS_PER_S   1000

`endif

// File: verilog/fps_pkg.sv
// Types shared by the fuel pump sequencer files.
// Assumes the constants header is compiled alongside.
`default_nettype none
package fps_pkg;
  typedef enum logic [3:0] {
    MODE_AUTO  = 4'b0001,
    MODE_FLUSH = 4'b0010,
    MODE_TEST  = 4'b0100,
    MODE_OFF   = 4'b1000
  } fps_mode_t;

  typedef struct packed {
    logic       inputSel;
    logic [3:0] modeSel;
    logic       tankSel;
    logic [4:0] leadSelA;
    logic [4:0] leadSelB;
    logic       overTemp;
    logic       estop;
  } fps_panel_t;

  typedef struct packed {
    logic cpuAOnLamp;
    logic cpuBOnLamp;
    logic nonCritAlarm;
    logic critAlarm;
  } fps_annun_t;
endpackage
`default_nettype wire

// File: verilog/fps_order_rom.sv
// Builds the start order of the five pumps of the operating tank from the lead pump.
// Assumes a one-hot lead selector input; a dead selector falls back to the first pump.
`default_nettype none
module fps_order_rom (
  input  wire logic [4:0]  leadOneHot,
  output logic      [14:0] order
);
  logic [2:0] lead;
  always_comb begin
    lead = 3'd0;
    for (int i = 4; i >= 0; i--) begin
      if (leadOneHot[i]) begin
        lead = 3'(i);
      end
    end
  end
  // Slot k holds pump (lead+k) mod 5 within the tank.
  for (genvar k = 0; k < 5; k++) begin : gSlot
    logic [3:0] s;
    assign s = 4'(lead) + 4'(k);
    assign order[k*3 +: 3] = (s >= 4'd5) ? 3'(s - 4'd5) : s[2:0];
  end
endmodule
`default_nettype wire

// File: testbench/fps_field_model.sv
// Field-side model: selector switches, pump starters and the issue flow source.
// Assumes the bench sets switch and fault commands just after a core clock edge.
`default_nettype none
module fps_field_model (
  input  wire logic                core_clk,
  input  wire logic                rst_n,
  input  wire fps_pkg::fps_panel_t panelCmd,
  input  wire logic [9:0]          failMask,
  input  wire logic [15:0]         flowCmd,
  input  wire logic [9:0]          pumpRun,
  output fps_pkg::fps_panel_t      panelPins,
  output logic      [9:0]          pumpFail,
  output logic      [15:0]         issueFlow,
  output logic      [15:0]         sysPressure
);
  timeunit 1ns;
  timeprecision 1ps;
  import fps_pkg::*;
  // ****************************************
  // Starters and sources
  // ****************************************
  // A starter trips one cycle after its pump is commanded on, so a pump just stopped can still report a fault for one cycle.
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      pumpFail <= 10'h000;
    end else begin
      pumpFail <= pumpRun & failMask;
    end
  end
  assign panelPins   = panelCmd;
  assign issueFlow   = (pumpRun != 10'h000) ? flowCmd : 16'h0000;
  assign sysPressure = 16'h0000;
endmodule
`default_nettype wire

// File: testbench/fps_sequencer_bench.sv
// Self-checking bench of the fuel pump sequencer over its AHB-Lite port and panel pins.
// Assumes the design files and the field model are compiled first.
`default_nettype none
`include "fps_params.svh"
module fps_sequencer_bench;
  timeunit 1ns;
  timeprecision 1ps;
  import fps_pkg::*;
  localparam logic [31:0] KEY = 32'h5A5A_C3C3; // Arbitrary unlock word for this bench.
  localparam fps_panel_t  BASE = '{1'b0, 4'h1, 1'b0, 5'h01, 5'h01, 1'b0, 1'b0};
  logic        core_clk, rst_n, hsel, hwrite, hreadyout, hresp, powerRestoredCold, clkEn;
  logic        cpuAFault, cpuBFault, activeSystemB, operTankB;
  logic [1:0]  htrans;
  logic [31:0] haddr, hwdata, hrdata, rdata;
  logic [9:0]  failMask, pumpRun, pumpFail;
  logic [15:0] issueFlow, sysPressure, flowCmd;
  logic [3:0]  leadPumpNum, lead;
  fps_panel_t  panelCmd, panelPins, pc;
  fps_annun_t  annun;
  fps_mode_t   activeMode;
  int          errTotal, nTests;
  logic [7:0]  spAddr [4] = '{`FPS_OFF_PRESS, `FPS_OFF_FLOW2, `FPS_OFF_FLOW3, `FPS_OFF_ESTAB};
  logic [15:0] spMin  [4] = '{`FPS_PRESS_MIN, `FPS_FLOW2_MIN, `FPS_FLOW3_MIN, `FPS_ESTAB_MIN};
  logic [15:0] spMax  [4] = '{`FPS_PRESS_MAX, `FPS_FLOW2_MAX, `FPS_FLOW3_MAX, `FPS_ESTAB_MAX};
  logic [15:0] spDef  [4] = '{`FPS_PRESS_DEF, `FPS_FLOW2_DEF, `FPS_FLOW3_DEF, `FPS_ESTAB_DEF};

  fps_sequencer #(.UNLOCK_KEY(KEY)) i_fps_sequencer (
    .core_clk(core_clk), .rst_n(rst_n), .clkEn(clkEn), .panelPins(panelPins), .cpuAFault(cpuAFault),
    .cpuBFault(cpuBFault), .powerRestoredCold(powerRestoredCold), .pumpFail(pumpFail), .issueFlow(issueFlow),
    .sysPressure(sysPressure), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(3'b010),
    .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .pumpRun(pumpRun), .annun(annun), .activeMode(activeMode), .activeSystemB(activeSystemB),
    .operTankB(operTankB), .leadPumpNum(leadPumpNum));

  fps_field_model i_fps_field_model (
    .core_clk(core_clk), .rst_n(rst_n), .panelCmd(panelCmd), .failMask(failMask), .flowCmd(flowCmd),
    .pumpRun(pumpRun), .panelPins(panelPins), .pumpFail(pumpFail), .issueFlow(issueFlow),
    .sysPressure(sysPressure));

  // ****************************************
  // Bus and compare tasks
  // ****************************************
  always #5 core_clk = ~core_clk;

  task automatic chkWord(input string nm, input logic [31:0] exp, input logic [31:0] got);
    nTests++;
    if (got !== exp) begin
      errTotal++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  // The address phase is held until hready is seen high, then the data phase likewise.
  task automatic busOp(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge core_clk);
    hsel   <= 1'b1;
    htrans <= 2'b10;
    hwrite <= wr;
    haddr  <= {24'h000000, a};
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hsel   <= 1'b0;
    hwdata <= d;
    do @(posedge core_clk); while (hreadyout !== 1'b1);
    rdata = hrdata;
    chkWord("response", 32'h0, {31'h0, hresp});
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    busOp(1'b1, a, d);
  endtask

  task automatic rdChk(input string nm, input logic [7:0] a, input logic [31:0] exp);
    busOp(1'b0, a, 32'h0);
    chkWord(nm, exp, rdata);
  endtask

  task automatic restart;
    rst_n <= 1'b0;
    cyc(8);
    rst_n <= 1'b1;
    cyc(5);
  endtask

  task automatic waitRun;
    for (int i = 0; i < 50 && pumpRun === 10'h000; i++) cyc(1);
  endtask

  task automatic close_out;
    $display("Comparisons %0d, mismatches %0d", nTests, errTotal);
    if (errTotal == 0 && nTests > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  always @(negedge core_clk) begin
    if (rst_n === 1'b1 && $countones(pumpRun) > 4) begin
      chkWord("run count", 32'd4, 32'($countones(pumpRun)));
    end
  end

  // ****************************************
  // Test sequence
  // ****************************************
  initial begin
    core_clk = 1'b0;
    rst_n = 1'b0;
    {hsel, hwrite, htrans, haddr, hwdata} = '0;
    {powerRestoredCold, cpuAFault, cpuBFault, failMask, flowCmd} = '0;
    errTotal = 0;
    nTests = 0;
    clkEn = 1'b1;
    panelCmd = BASE;
    restart();
    chkWord("lamps", 32'hC, {28'h0, annun});
    for (int i = 0; i < 4; i++) begin
      rdChk("set point default", spAddr[i], {16'h0, spDef[i]});
      wr(spAddr[i], {16'h0, spMax[i] + 16'h1});
      rdChk("set point high", spAddr[i], {16'h0, spMax[i]});
      wr(spAddr[i], {16'h0, spMin[i] - 16'h1});
      rdChk("set point low", spAddr[i], {16'h0, spMin[i]});
    end
    rdChk("unmapped", 8'h40, 32'h0);
    // A locked default write must not survive the reload.
    wr(`FPS_OFF_PRESS, 32'd600);
    wr(`FPS_OFF_DEFSEL, 32'h0);
    wr(`FPS_OFF_DEFDATA, 32'd500);
    wr(`FPS_OFF_CTRL, 32'h2);
    rdChk("reload", `FPS_OFF_PRESS, {16'h0, `FPS_PRESS_DEF});
    wr(`FPS_OFF_PASSWORD, KEY);
    rdChk("unlock", `FPS_OFF_DEFSEL, 32'h4);
    wr(`FPS_OFF_DEFDATA, 32'd500);
    wr(`FPS_OFF_PRESS, 32'd900);
    powerRestoredCold <= 1'b1;
    cyc(1);
    powerRestoredCold <= 1'b0;
    cyc(2);
    rdChk("cold restore", `FPS_OFF_PRESS, 32'd500);
    wr(`FPS_OFF_DEFSEL, 32'h3);
    wr(`FPS_OFF_DEFDATA, 32'd100);
    wr(`FPS_OFF_CTRL, 32'h2);
    rdChk("default clamp", `FPS_OFF_ESTAB, {16'h0, `FPS_ESTAB_MAX});
    wr(`FPS_OFF_PASSWORD, 32'h0);
    rdChk("relock", `FPS_OFF_DEFSEL, 32'h3);
    for (int m = 0; m < 4; m++) begin
      pc = BASE;
      pc.modeSel = 4'h1 << m;
      panelCmd <= pc;
      cyc(4);
      chkWord("mode", {28'h0, 4'h1 << m}, {28'h0, activeMode});
      busOp(1'b0, `FPS_OFF_STATUS, 32'h0);
      chkWord("status mode", {28'h0, 4'h1 << m}, {28'h0, rdata[3:0]});
    end
    chkWord("off mode runs", 32'h0, {22'h0, pumpRun});
    for (int t = 0; t < 2; t++) begin
      for (int k = 0; k < 5; k++) begin
        pc = BASE;
        pc.tankSel = 1'(t);
        pc.inputSel = 1'(t);
        if (t == 1) pc.leadSelB = 5'h01 << k;
        else pc.leadSelA = 5'h01 << k;
        panelCmd <= pc;
        restart();
        waitRun();
        lead = 4'(5 * t + k + 1);
        chkWord("lead run", {22'h0, 10'h001 << (lead - 4'h1)}, {22'h0, pumpRun});
        busOp(1'b0, `FPS_OFF_STATUS, 32'h0);
        chkWord("status", {20'h0, lead, 1'(t), 1'(t), 6'h01}, {20'h0, rdata[11:0]});
        chkWord("panel pins", {26'h0, lead, 1'(t), 1'(t)}, {26'h0, leadPumpNum, operTankB, activeSystemB});
      end
    end
    // Pump ten is running now; its starter trips.
    failMask <= 10'h200;
    cyc(6);
    chkWord("failed pump off", 32'h0, {31'h0, pumpRun[9]});
    chkWord("next pump", 32'h020, {22'h0, pumpRun});
    busOp(1'b0, `FPS_OFF_PUMPS, 32'h0);
    chkWord("failed pump disabled", 32'h1, {31'h0, rdata[9]});
    failMask <= 10'h000;
    panelCmd <= BASE;
    restart();
    waitRun();
    pc = BASE;
    pc.estop = 1'b1;
    panelCmd <= pc;
    cyc(6);
    chkWord("estop runs", 32'h0, {22'h0, pumpRun});
    chkWord("estop alarm", 32'h1, {31'h0, annun.critAlarm});
    cyc(30);
    chkWord("estop restart", 32'h0, {22'h0, pumpRun});
    panelCmd <= BASE;
    restart();
    cpuAFault <= 1'b1;
    cyc(4);
    chkWord("fault a lamps", 32'h6, {28'h0, annun});
    cpuAFault <= 1'b0;
    restart();
    cpuBFault <= 1'b1;
    cyc(4);
    chkWord("fault b lamps", 32'hA, {28'h0, annun});
    cpuBFault <= 1'b0;
    restart();
    pc = BASE;
    pc.overTemp = 1'b1;
    panelCmd <= pc;
    cyc(4);
    chkWord("over temperature", 32'h1, {31'h0, annun.nonCritAlarm});
    // With the clock enable low the mode must not follow the selector.
    pc.modeSel = 4'h8;
    clkEn <= 1'b0;
    panelCmd <= pc;
    cyc(4);
    chkWord("frozen mode", {28'h0, MODE_AUTO}, {28'h0, activeMode});
    clkEn <= 1'b1;
    cyc(4);
    chkWord("thawed mode", {28'h0, MODE_OFF}, {28'h0, activeMode});
    close_out();
  end

  // The whole sequence takes a few hundred cycles; this leaves wide margin.
  initial begin
    #400000;
    errTotal++;
    $display("[ERR] run time expected finish seen timeout");
    close_out();
  end
endmodule
`default_nettype wire
